// File: common/csc_map.vh
// Register offsets, field positions and the control register reset value of the clock source control block
`ifndef CSC_MAP_VH
`define CSC_MAP_VH
`define CSC_CTL_OFF 12'h000
`define CSC_CFG_OFF 12'h004
`define CSC_INT_OFF 12'h008
`define CSC_ADD_OFF 12'h00C
`define CSC_BD_OFF 12'h010
`define CSC_RSC_OFF 12'h014
`define CSC_DSV_OFF 12'h018
`define CSC_PWR_OFF 12'h01C
`define CSC_CTL_RST 32'h00000001
// Source indices: stable flag and ready interrupt enable positions
`define CSC_SRC_RC8M 0
`define CSC_SRC_XTAL 1
`define CSC_SRC_PLL0 2
`define CSC_SRC_PLL1 3
`define CSC_SRC_PLL2 4
`define CSC_SRC_RC48 5
`define CSC_SRC_SLOW 6
`define CSC_SRC_RC40 7
// Control register bit positions
`define CSC_CTL_RC8M_EN 0
`define CSC_CTL_RC8M_STB 1
`define CSC_CTL_XTAL_EN 16
`define CSC_CTL_XTAL_STB 17
`define CSC_CTL_XTAL_BPS 18
`define CSC_CTL_MON_EN 19
`define CSC_CTL_PLL0_EN 24
`define CSC_CTL_PLL0_STB 25
`define CSC_CTL_PLL1_EN 26
`define CSC_CTL_PLL1_STB 27
`define CSC_CTL_PLL2_EN 28
`define CSC_CTL_PLL2_STB 29
// Interrupt register: flags 7:0, enables 15:8, stuck flag 16
`define CSC_INT_STUCK 16
// Sys clock switch codes
`define CSC_SW_RC8M 2'h0
`define CSC_SW_XTAL 2'h1
`define CSC_SW_PLL 2'h2
// Configuration register fields
`define CSC_CFG_SW_LSB 0
`define CSC_CFG_SWS_LSB 2
`define CSC_CFG_PLLSRC_LSB 16
`define CSC_CFG_CKO_LSB 24
// Clock output mux codes
`define CSC_CKO_NONE 4'h0
`define CSC_CKO_SYS 4'h4
`define CSC_CKO_RC8M 4'h5
`define CSC_CKO_XTAL 4'h6
`define CSC_CKO_PLL_D2 4'h7
`define CSC_CKO_PLL1 4'h8
`define CSC_CKO_PLL2_D2 4'h9
`define CSC_CKO_XTAL_B 4'hA
`define CSC_CKO_PLL2 4'hB
`define CSC_CKO_RC48 4'hC
`define CSC_CKO_RC48_D8 4'hD
// PLL source codes
`define CSC_PSRC_RC8M 2'h0
`define CSC_PSRC_XTAL 2'h1
`define CSC_PSRC_RC48 2'h2
`endif

// File: hw/csc_sync.v
// Two-stage synchroniser for a bus of asynchronous levels
`default_nettype none
module csc_sync #(
	parameter W = 8
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Levels
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);
	reg [W-1:0] meta_r;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// File: hw/csc_cko_dec.v
// Decoder of the clock output select field into a one-hot source choice
`default_nettype none
`include "csc_map.vh"
module csc_cko_dec (
	// Select code
	input wire [3:0] sel,
	// One-hot choice: none,sys,rc8m,xtal,pll/2,pll1,pll2/2,pll2,rc48,rc48/8
	output reg [9:0] onehot
);
	always @* begin
		onehot = 10'h000;
		case (sel)
			`CSC_CKO_SYS: onehot = 10'h002;
			`CSC_CKO_RC8M: onehot = 10'h004;
			`CSC_CKO_XTAL: onehot = 10'h008;
			`CSC_CKO_XTAL_B: onehot = 10'h008;
			`CSC_CKO_PLL_D2: onehot = 10'h010;
			`CSC_CKO_PLL1: onehot = 10'h020;
			`CSC_CKO_PLL2_D2: onehot = 10'h040;
			`CSC_CKO_PLL2: onehot = 10'h080;
			`CSC_CKO_RC48: onehot = 10'h100;
			`CSC_CKO_RC48_D8: onehot = 10'h200;
			default: onehot = 10'h001;
		endcase
	end
endmodule
`default_nettype wire

// File: hw/csc_top.v
// Clock source control: oscillator enables, stable flags, clock switch and monitor
`default_nettype none
`include "csc_map.vh"
module csc_top (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Power mode and monitor inputs
	input wire deep_sleep_req,
	input wire standby_req,
	input wire xtal_fail,
	// Raw stable indications: rc8m,xtal,pll0,pll1,pll2,rc48,slow,rc40
	input wire [7:0] src_stable_raw,
	// Oscillator and PLL enables
	output reg rc_8m_on,
	output reg fast_xtal_on,
	output reg fast_xtal_bypass_on,
	output reg main_pll_on,
	output reg second_pll_on,
	output reg third_pll_on,
	output reg rc_48m_on,
	output reg slow_xtal_on,
	output reg slow_xtal_bypass_on,
	output reg rc_40k_on,
	// Clock muxes and events
	output reg [1:0] sys_clock_sel,
	output reg [1:0] rtc_source_sel,
	output reg [9:0] clock_out_onehot,
	output reg [1:0] core_voltage_sel,
	output reg irq,
	output reg nmi_event
);
	localparam ST_RUN = 3'b001;
	localparam ST_SLEEP = 3'b010;
	localparam ST_WAKE = 3'b100;
	reg [2:0] state_r;
	reg [31:0] ctl_r;
	reg [1:0] sw_r;
	reg [1:0] pll_src_r;
	reg [3:0] cko_r;
	reg [7:0] rdy_ie_r;
	reg [7:0] rdy_flag_r;
	reg stuck_r;
	reg rc48_en_r;
	reg slow_en_r;
	reg slow_bps_r;
	reg [1:0] rtc_sel_r;
	reg rc40_en_r;
	reg [1:0] dsv_r;
	reg [7:0] stb_prev_r;
	reg fail_prev_r;
	wire [7:0] stb_s;
	wire [9:0] cko_dec;
	wire [1:0] misc_s;
	wire wr_en = psel & penable & pwrite;
	wire xtal_en = ctl_r[`CSC_CTL_XTAL_EN];
	wire pll_en = ctl_r[`CSC_CTL_PLL0_EN];
	wire mon_en = ctl_r[`CSC_CTL_MON_EN];
	wire sleeping = (state_r == ST_SLEEP);
	wire fail_sync = misc_s[0];
	wire fail_edge = fail_sync & ~fail_prev_r & mon_en & xtal_en;
	wire pll_uses_xtal = (pll_src_r == `CSC_PSRC_XTAL);

	csc_sync #(.W(8)) u_sync_stb (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(src_stable_raw),
		.sync_out(stb_s)
	);
	csc_sync #(.W(2)) u_sync_misc (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({deep_sleep_req | standby_req, xtal_fail}),
		.sync_out(misc_s)
	);
	csc_cko_dec u_cko (
		.sel(cko_r),
		.onehot(cko_dec)
	);

	// Is a given switch code stable and usable
	function src_ready;
		input [1:0] code;
		input [7:0] stb;
		begin
			case (code)
				`CSC_SW_XTAL: src_ready = stb[`CSC_SRC_XTAL];
				`CSC_SW_PLL: src_ready = stb[`CSC_SRC_PLL0];
				default: src_ready = stb[`CSC_SRC_RC8M];
			endcase
		end
	endfunction

	// Power mode sequencing
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_RUN;
		end else begin
			case (state_r)
				ST_RUN: if (misc_s[1]) state_r <= ST_SLEEP;
				ST_SLEEP: if (!misc_s[1]) state_r <= ST_WAKE;
				ST_WAKE: state_r <= ST_RUN;
				default: state_r <= ST_RUN;
			endcase
		end
	end

	// Control and configuration registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= `CSC_CTL_RST;
			sw_r <= `CSC_SW_RC8M;
			pll_src_r <= `CSC_PSRC_RC8M;
			cko_r <= 4'h0;
			rdy_ie_r <= 8'h00;
			rc48_en_r <= 1'b0;
			slow_en_r <= 1'b0;
			slow_bps_r <= 1'b0;
			rtc_sel_r <= 2'h0;
			rc40_en_r <= 1'b0;
			dsv_r <= 2'h0;
		end else begin
			if (wr_en && paddr == `CSC_CTL_OFF) begin
				// keep sources feeding the system clock
				ctl_r[`CSC_CTL_RC8M_EN] <= pwdata[`CSC_CTL_RC8M_EN] |
					(sys_clock_sel == `CSC_SW_RC8M) |
					(sys_clock_sel == `CSC_SW_PLL && pll_src_r == `CSC_PSRC_RC8M);
				ctl_r[`CSC_CTL_XTAL_EN] <= pwdata[`CSC_CTL_XTAL_EN] |
					(sys_clock_sel == `CSC_SW_XTAL) |
					(sys_clock_sel == `CSC_SW_PLL && pll_uses_xtal);
				if (!xtal_en)
					ctl_r[`CSC_CTL_XTAL_BPS] <= pwdata[`CSC_CTL_XTAL_BPS];
				ctl_r[`CSC_CTL_MON_EN] <= pwdata[`CSC_CTL_MON_EN];
				ctl_r[`CSC_CTL_PLL0_EN] <= pwdata[`CSC_CTL_PLL0_EN] |
					(sys_clock_sel == `CSC_SW_PLL);
				ctl_r[`CSC_CTL_PLL1_EN] <= pwdata[`CSC_CTL_PLL1_EN];
				ctl_r[`CSC_CTL_PLL2_EN] <= pwdata[`CSC_CTL_PLL2_EN];
			end
			if (wr_en && paddr == `CSC_CFG_OFF) begin
				sw_r <= pwdata[`CSC_CFG_SW_LSB +: 2];
				pll_src_r <= pwdata[`CSC_CFG_PLLSRC_LSB +: 2];
				cko_r <= pwdata[`CSC_CFG_CKO_LSB +: 4];
			end
			if (wr_en && paddr == `CSC_INT_OFF)
				rdy_ie_r <= pwdata[15:8];
			if (wr_en && paddr == `CSC_ADD_OFF)
				rc48_en_r <= pwdata[0];
			if (wr_en && paddr == `CSC_BD_OFF) begin
				slow_en_r <= pwdata[0];
				if (!slow_en_r)
					slow_bps_r <= pwdata[2];
				rtc_sel_r <= pwdata[9:8];
			end
			if (wr_en && paddr == `CSC_RSC_OFF)
				rc40_en_r <= pwdata[0];
			if (wr_en && paddr == `CSC_DSV_OFF)
				dsv_r <= pwdata[1:0];
			// PLLs off on deep-sleep or standby
			if (sleeping || (fail_edge && pll_uses_xtal)) begin
				ctl_r[`CSC_CTL_PLL0_EN] <= 1'b0;
				ctl_r[`CSC_CTL_PLL1_EN] <= 1'b0;
				ctl_r[`CSC_CTL_PLL2_EN] <= 1'b0;
			end
			// RC 8 MHz running for the wake-up switch
			if (sleeping)
				ctl_r[`CSC_CTL_RC8M_EN] <= 1'b1;
			if (fail_edge) begin
				ctl_r[`CSC_CTL_XTAL_EN] <= 1'b0;
				// PLL disabled unless RC 8 MHz drives system
				if (sys_clock_sel != `CSC_SW_RC8M)
					ctl_r[`CSC_CTL_PLL0_EN] <= 1'b0;
				if (rtc_sel_r == 2'h3)
					rtc_sel_r <= 2'h0;
			end
		end
	end

	// Stable flags, ready flags and stuck flag
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stb_prev_r <= 8'h00;
			rdy_flag_r <= 8'h00;
			stuck_r <= 1'b0;
			fail_prev_r <= 1'b0;
		end else begin
			stb_prev_r <= stb_s;
			fail_prev_r <= fail_sync;
			// ready flags set on rising stable; set beats clear
			if (wr_en && paddr == `CSC_INT_OFF)
				rdy_flag_r <= (rdy_flag_r & ~pwdata[7:0]) | (stb_s & ~stb_prev_r);
			else
				rdy_flag_r <= rdy_flag_r | (stb_s & ~stb_prev_r);
			// stuck flag, cleared by writing one
			if (fail_edge)
				stuck_r <= 1'b1;
			else if (wr_en && paddr == `CSC_INT_OFF && pwdata[`CSC_INT_STUCK])
				stuck_r <= 1'b0;
		end
	end

	// System clock switch and outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clock_sel <= `CSC_SW_RC8M;
			rtc_source_sel <= 2'h0;
			clock_out_onehot <= 10'h000;
			core_voltage_sel <= 2'h0;
			irq <= 1'b0;
			nmi_event <= 1'b0;
			rc_8m_on <= 1'b1;
			fast_xtal_on <= 1'b0;
			fast_xtal_bypass_on <= 1'b0;
			main_pll_on <= 1'b0;
			second_pll_on <= 1'b0;
			third_pll_on <= 1'b0;
			rc_48m_on <= 1'b0;
			slow_xtal_on <= 1'b0;
			slow_xtal_bypass_on <= 1'b0;
			rc_40k_on <= 1'b0;
		end else begin
			// forced fallback, held until stuck flag cleared
			// restore only after stuck flag clears
			if (fail_edge || stuck_r) begin
				sys_clock_sel <= (sys_clock_sel == `CSC_SW_PLL && !pll_uses_xtal) ?
					sys_clock_sel : `CSC_SW_RC8M;
			end else if (state_r == ST_WAKE && sys_clock_sel != `CSC_SW_RC8M) begin
				sys_clock_sel <= `CSC_SW_RC8M;
			end else if (sw_r != sys_clock_sel && src_ready(sw_r, rdy_stb(stb_s))) begin
				sys_clock_sel <= sw_r;
			end
			rtc_source_sel <= rtc_sel_r;
			clock_out_onehot <= cko_dec;
			core_voltage_sel <= dsv_r;
			irq <= |(rdy_flag_r & rdy_ie_r);
			nmi_event <= fail_edge;
			// monitor keeps RC running; RC enable
			rc_8m_on <= ctl_r[`CSC_CTL_RC8M_EN] | mon_en;
			// bypass drives the crystal path from the input pin
			fast_xtal_on <= xtal_en;
			fast_xtal_bypass_on <= xtal_en & ctl_r[`CSC_CTL_XTAL_BPS];
			main_pll_on <= pll_en;
			second_pll_on <= ctl_r[`CSC_CTL_PLL1_EN];
			third_pll_on <= ctl_r[`CSC_CTL_PLL2_EN];
			rc_48m_on <= rc48_en_r;
			slow_xtal_on <= slow_en_r;
			slow_xtal_bypass_on <= slow_en_r & slow_bps_r;
			rc_40k_on <= rc40_en_r;
		end
	end

	// crystal and PLL0 stable flags only count while enabled
	function [7:0] rdy_stb;
		input [7:0] stb;
		begin
			rdy_stb = stb;
			rdy_stb[`CSC_SRC_XTAL] = stb[`CSC_SRC_XTAL] & ctl_r[`CSC_CTL_XTAL_EN];
			rdy_stb[`CSC_SRC_PLL0] = stb[`CSC_SRC_PLL0] & ctl_r[`CSC_CTL_PLL0_EN];
		end
	endfunction

	// APB read and answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`CSC_CTL_OFF: prdata <= ctl_r |
						({31'h0, stb_s[`CSC_SRC_RC8M]} << `CSC_CTL_RC8M_STB) |
						({31'h0, stb_s[`CSC_SRC_XTAL]} << `CSC_CTL_XTAL_STB) |
						({31'h0, stb_s[`CSC_SRC_PLL0]} << `CSC_CTL_PLL0_STB) |
						({31'h0, stb_s[`CSC_SRC_PLL1]} << `CSC_CTL_PLL1_STB) |
						({31'h0, stb_s[`CSC_SRC_PLL2]} << `CSC_CTL_PLL2_STB);
					`CSC_CFG_OFF: prdata <= {4'h0, cko_r, 6'h00, pll_src_r, 12'h000,
						sys_clock_sel, sw_r};
					`CSC_INT_OFF: prdata <= {15'h0000, stuck_r, rdy_ie_r, rdy_flag_r};
					`CSC_ADD_OFF: prdata <= {30'h0, stb_s[`CSC_SRC_RC48], rc48_en_r};
					`CSC_BD_OFF: prdata <= {22'h0, rtc_sel_r, 5'h00, slow_bps_r,
						stb_s[`CSC_SRC_SLOW], slow_en_r};
					`CSC_RSC_OFF: prdata <= {30'h0, stb_s[`CSC_SRC_RC40], rc40_en_r};
					`CSC_DSV_OFF: prdata <= {30'h0, dsv_r};
					`CSC_PWR_OFF: prdata <= {29'h0, state_r};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// File: test/csc_asserts.sv
// Port checks of the clock source control block
`default_nettype none
`include "csc_map.vh"
module csc_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Modes and sources
	input wire logic deep_sleep_req,
	input wire logic standby_req,
	input wire logic [7:0] src_stable_raw,
	input wire logic rc_8m_on,
	input wire logic fast_xtal_on,
	input wire logic fast_xtal_bypass_on,
	input wire logic main_pll_on,
	input wire logic second_pll_on,
	input wire logic third_pll_on,
	// Muxes and events
	input wire logic [1:0] sys_clock_sel,
	input wire logic [9:0] clock_out_onehot,
	input wire logic [1:0] core_voltage_sel,
	input wire logic nmi_event
);
	timeunit 1ns;
	timeprecision 1ns;
	logic dsv_wr;
	logic [1:0] dsv_r;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	assign dsv_wr = psel && penable && pready && pwrite && paddr == `CSC_DSV_OFF;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dsv_r <= 2'h0;
		end else if (dsv_wr) begin
			dsv_r <= pwdata[1:0];
		end
	end
	chk_apb_answer: assert property (psel && !penable |=> pready) else $error("No answer");
	chk_pll_sleep: assert property ((deep_sleep_req || standby_req) [*6] |->
		!(main_pll_on || second_pll_on || third_pll_on)) else $error("PLL on in sleep");
	chk_bypass_hold: assert property (fast_xtal_on && $past(fast_xtal_on) |->
		$stable(fast_xtal_bypass_on)) else $error("Bypass changed");
	chk_switch_stable: assert property (sys_clock_sel != 2'h0 && $changed(sys_clock_sel) |->
		($past(src_stable_raw, 2) >> sys_clock_sel) & 8'h01) else $error("Early switch");
	chk_rc8m_kept: assert property (sys_clock_sel == 2'h0 |-> rc_8m_on)
		else $error("Source stopped");
	chk_out_onehot: assert property ($past(presetn) |-> $onehot(clock_out_onehot))
		else $error("Clock out not one-hot");
	chk_vsel_write: assert property ($past(dsv_wr) |-> ##[0:1] core_voltage_sel == dsv_r)
		else $error("Voltage select wrong");
	chk_nmi_pulse: assert property (nmi_event |=> !nmi_event) else $error("Event too long");
	chk_fail_off: assert property (nmi_event |-> ##[0:2] !fast_xtal_on)
		else $error("Crystal kept on");
	chk_fail_fallback: assert property (nmi_event |-> ##[0:2] sys_clock_sel != 2'h1)
		else $error("No fallback");
endmodule
bind csc_top csc_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.pready, .deep_sleep_req, .standby_req, .src_stable_raw, .rc_8m_on, .fast_xtal_on,
	.fast_xtal_bypass_on, .main_pll_on, .second_pll_on, .third_pll_on, .sys_clock_sel,
	.clock_out_onehot, .core_voltage_sel, .nmi_event);
`default_nettype wire

// File: test/csc_osc_model.sv
// Oscillator and PLL cells answering the enables after a start-up delay
`default_nettype none
module csc_osc_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Enables and pace
	input wire logic [7:0] src_on,
	input wire logic slow,
	// Stable levels
	output logic [7:0] src_stable_raw
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] cnt [8];
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < 8; i++) begin
			if (!presetn || !src_on[i]) begin
				cnt[i] <= 6'h00;
			end else if (cnt[i] != 6'h3F) begin
				cnt[i] <= cnt[i] + 6'h01;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			src_stable_raw[i] = src_on[i] && cnt[i] > (slow ? 6'h28 : 6'h03);
		end
	end
endmodule
`default_nettype wire

// File: test/csc_tb.sv
// Self-checking testbench of the clock source control block
`default_nettype none
`include "csc_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic deep_sleep_req = 1'b0;
	logic standby_req = 1'b0;
	logic xtal_fail = 1'b0;
	logic slow = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, irq, nmi_event, rc_8m_on, fast_xtal_on, fast_xtal_bypass_on;
	logic main_pll_on, second_pll_on, third_pll_on, rc_48m_on, slow_xtal_on;
	logic slow_xtal_bypass_on, rc_40k_on;
	logic [7:0] src_stable_raw;
	logic [1:0] sys_clock_sel, rtc_source_sel, core_voltage_sel;
	logic [9:0] clock_out_onehot;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 32'hD1CB;
	always #50 pclk = ~pclk;
	csc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .deep_sleep_req, .standby_req, .xtal_fail, .src_stable_raw, .rc_8m_on,
		.fast_xtal_on, .fast_xtal_bypass_on, .main_pll_on, .second_pll_on, .third_pll_on,
		.rc_48m_on, .slow_xtal_on, .slow_xtal_bypass_on, .rc_40k_on, .sys_clock_sel,
		.rtc_source_sel, .clock_out_onehot, .core_voltage_sel, .irq, .nmi_event);
	csc_osc_model u_osc (.pclk, .presetn, .slow, .src_stable_raw, .src_on({rc_40k_on,
		slow_xtal_on, rc_48m_on, third_pll_on, second_pll_on, main_pll_on, fast_xtal_on,
		rc_8m_on}));
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_mismatch++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h00000000);
	endtask
	task automatic wait_sys(input logic [1:0] s);
		int n;
		n = 0;
		while (sys_clock_sel !== s && n < 100) begin
			@(posedge pclk);
			n++;
		end
		if (sys_clock_sel !== s) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	function automatic logic [9:0] ohx(input int c);
		int t[14] = '{0, 0, 0, 0, 1, 2, 3, 4, 5, 6, 3, 7, 8, 9};
		return 10'h001 << t[c];
	endfunction
	// Read results against the noted expectations
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			cmp("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());
			cmp("pslverr", 32'h0, pslverr);
		end
	end
	initial begin
		int n;
		logic [31:0] d;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd(`CSC_CTL_OFF, 32'hFFFFFFFD, `CSC_CTL_RST);
		cmp("sys_sel", 2'h0, sys_clock_sel);
		apb(1'b1, 12'h100, $random(seed));
		rd(12'h100, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, `CSC_CTL_OFF, 32'h00040001);
		apb(1'b1, `CSC_CTL_OFF, 32'h00050001);
		apb(1'b1, `CSC_CFG_OFF, 32'h00000001);
		repeat (3) @(posedge pclk);
		cmp("sys_wait", 2'h0, sys_clock_sel);
		apb(1'b1, `CSC_CTL_OFF, 32'h00010001);
		cmp("bypass", 1'b1, fast_xtal_bypass_on);
		wait_sys(2'h1);
		cmp("sys_xtal", 2'h1, sys_clock_sel);
		apb(1'b1, `CSC_CTL_OFF, 32'h00000001);
		rd(`CSC_CTL_OFF, 32'h00010000, 32'h00010000);
		slow <= 1'b0;
		apb(1'b1, `CSC_CTL_OFF, 32'h15010001);
		for (int i = 0; i < 3; i++) apb(1'b1, 12'h00C + 12'(4 * i), 32'h00000005);
		repeat (20) @(posedge pclk);
		cmp("irq_masked", 1'b0, irq);
		cmp("src_on", 4'hF, {rc_48m_on, slow_xtal_on, slow_xtal_bypass_on, rc_40k_on});
		rd(`CSC_INT_OFF, 32'h000000FF, 32'h000000FF);
		rd(`CSC_CTL_OFF, 32'h2A020002, 32'h2A020002);
		for (int i = 0; i < 3; i++) rd(12'h00C + 12'(4 * i), 32'h2, 32'h2);
		apb(1'b1, `CSC_INT_OFF, 32'h00000200);
		repeat (3) @(posedge pclk);
		cmp("irq_on", 1'b1, irq);
		apb(1'b1, `CSC_INT_OFF, 32'h000002FF);
		repeat (3) @(posedge pclk);
		cmp("irq_clr", 1'b0, irq);
		for (int c = 0; c < 14; c++) begin
			apb(1'b1, `CSC_CFG_OFF, {4'h0, 4'(c), 24'h000001});
			repeat (3) @(posedge pclk);
			cmp("clock_out", ohx(c), clock_out_onehot);
		end
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			d[1:0] = 2'(i);
			apb(1'b1, `CSC_DSV_OFF, d);
			repeat (3) @(posedge pclk);
			cmp("core_volt", d[1:0], core_voltage_sel);
		end
		// sleep with the PLL as system clock
		apb(1'b1, `CSC_CFG_OFF, 32'h00000002);
		wait_sys(2'h2);
		cmp("sys_pll", 2'h2, sys_clock_sel);
		deep_sleep_req <= 1'b1;
		repeat (6) @(posedge pclk);
		cmp("plls_off", 3'h0, {main_pll_on, second_pll_on, third_pll_on});
		deep_sleep_req <= 1'b0;
		repeat (6) @(posedge pclk);
		cmp("wake_rc8m", 2'h0, sys_clock_sel);
		// standby with the second and third PLL running
		apb(1'b1, `CSC_CTL_OFF, 32'h14010001);
		standby_req <= 1'b1;
		repeat (6) @(posedge pclk);
		cmp("plls_stby", 3'h0, {main_pll_on, second_pll_on, third_pll_on});
		standby_req <= 1'b0;
		repeat (6) @(posedge pclk);
		apb(1'b1, `CSC_CFG_OFF, 32'h00000001);
		wait_sys(2'h1);
		cmp("sys_xtal2", 2'h1, sys_clock_sel);
		apb(1'b1, `CSC_BD_OFF, 32'h00000301);
		apb(1'b1, `CSC_CTL_OFF, 32'h00090000);
		repeat (3) @(posedge pclk);
		cmp("rc8m_held", 1'b1, rc_8m_on);
		xtal_fail <= 1'b1;
		for (n = 0; n < 10 && nmi_event !== 1'b1; n++) @(posedge pclk);
		cmp("nmi", 1'b1, nmi_event);
		if (nmi_event !== 1'b1) stop_test();
		repeat (3) @(posedge pclk);
		cmp("xtal_off", 1'b0, fast_xtal_on);
		cmp("fallback", 2'h0, sys_clock_sel);
		cmp("rtc_sel", 2'h0, rtc_source_sel);
		rd(`CSC_INT_OFF, 32'h00010000, 32'h00010000);
		xtal_fail <= 1'b0;
		apb(1'b1, `CSC_INT_OFF, 32'h00010000);
		rd(`CSC_INT_OFF, 32'h00010000, 32'h0);
		apb(1'b1, `CSC_CTL_OFF, 32'h00000001);
		repeat (4) @(posedge pclk);
		stop_test();
	end
endmodule
`default_nettype wire
